// ==== verilog/dcwir_regs.sv ====
// Config, watchdog control and identity register bank on Avalon-MM
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module dcwir_regs (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [dcwir_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic lockup_i,
  input wire logic [7:0] lockup_chans_i,
  output logic [7:0] chan_abort_o,
  output logic irq_abort_o,
  output logic irq_o
);
  import dcwir_pkg::*;

  // ----------------------------------------------------------------
  // Constant words
  // ----------------------------------------------------------------
  logic [31:0] build_cfg;
  logic [31:0] ident;
  assign build_cfg = {2'b00, CFG_BUF_DEP, CFG_RD_Q_DEP, 1'b0, CFG_RD_CAP,
                      CFG_WR_Q_DEP, 1'b0, CFG_WR_CAP, 1'b0, CFG_WIDTH}; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5] [RULE6]
  assign ident = {7'h00, INTEG_CFG, ID_REVISION, ID_DESIGNER, ID_PART}; // [RULE11] [RULE13]

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait cycle on reads so read data can come from a register
  logic rd_pend_q;
  logic wr_acc;
  logic rd_acc;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= avs_read_i && !rd_pend_q;
    end
  end
  assign avs_waitrequest_o = avs_read_i && !rd_pend_q;
  assign rd_acc = avs_read_i && rd_pend_q;
  assign wr_acc = avs_write_i && avs_byteenable_i[0];

  // ----------------------------------------------------------------
  // Watchdog control
  // ----------------------------------------------------------------
  logic notify_only_q;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      notify_only_q <= WD_RESET;
    end else if (wr_acc && avs_address_i == OFF_WD_CTRL) begin
      // Changing this mid-transfer is legal but best done with channels stopped [RULE9]
      notify_only_q <= avs_writedata_i[WD_NOTIFY_BIT];
    end
  end

  // Abort only when the notify-only mode is off
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chan_abort_o <= 8'h00;
    end else begin
      chan_abort_o <= (lockup_i && !notify_only_q) ? lockup_chans_i : 8'h00; // [RULE7] [RULE8]
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_abort_o <= 1'b0;
    end else begin
      irq_abort_o <= lockup_i; // [RULE7] [RULE8]
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_clr;
  assign irq_evt[IRQ_LOCKUP_BIT] = lockup_i;
  assign irq_evt[IRQ_ABORT_BIT] = lockup_i && !notify_only_q;
  assign irq_clr = (wr_acc && avs_address_i == OFF_IRQ_STAT) ?
                   avs_writedata_i[IRQ_W-1:0] : '0;
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_W; gi++) begin : g_stat
      // Set wins over a simultaneous clear so no event is lost
      always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          irq_stat_q[gi] <= 1'b0;
        end else if (irq_evt[gi]) begin
          irq_stat_q[gi] <= 1'b1;
        end else if (irq_clr[gi]) begin
          irq_stat_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_mask_q <= IRQ_MASK_RESET;
    end else if (wr_acc && avs_address_i == OFF_IRQ_MASK) begin
      irq_mask_q <= avs_writedata_i[IRQ_W-1:0];
    end
  end
  assign irq_o = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Writes to config and id offsets fall through untouched [RULE14]
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = ZERO_WORD;
    case (avs_address_i)
      OFF_BUILD_CFG: rd_mux = build_cfg; // [RULE14]
      OFF_WD_CTRL: rd_mux = {31'h0000_0000, notify_only_q};
      OFF_IRQ_STAT: rd_mux = {30'h0000_0000, irq_stat_q};
      OFF_IRQ_MASK: rd_mux = {30'h0000_0000, irq_mask_q};
      OFF_ID0: rd_mux = {24'h00_0000, ident[7:0]}; // [RULE10] [RULE12]
      OFF_ID1: rd_mux = {24'h00_0000, ident[15:8]}; // [RULE10]
      OFF_ID2: rd_mux = {24'h00_0000, ident[23:16]}; // [RULE10]
      OFF_ID3: rd_mux = {24'h00_0000, ident[31:24]}; // [RULE10] [RULE13]
      default: rd_mux = ZERO_WORD;
    endcase
  end

  dcwir_rdata_reg u_rdata (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .load_i(avs_read_i && !rd_pend_q),
    .data_i(rd_mux),
    .data_o(avs_readdata_o)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_abort_mode;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (lockup_i && !notify_only_q) |=> (chan_abort_o == $past(lockup_chans_i));
  endproperty
  a_abort_mode: assert property (p_abort_mode) else $error("Abort missing"); // [RULE7]

  property p_notify_only;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (lockup_i && notify_only_q) |=> (chan_abort_o == 8'h00) && irq_abort_o;
  endproperty
  a_notify_only: assert property (p_notify_only) else $error("Abort in notify mode"); // [RULE8]

  property p_irq_follow;
    @(posedge ref_clk_i) disable iff (!rstn_i) lockup_i |=> irq_abort_o;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("Abort irq missing"); // [RULE7]

  property p_cfg_read;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (rd_acc && avs_address_i == OFF_BUILD_CFG) |->
      (avs_readdata_o[29:20] == CFG_BUF_DEP) && (avs_readdata_o[19:16] == CFG_RD_Q_DEP);
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("Buffer fields wrong"); // [RULE1]

  property p_cfg_caps;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (rd_acc && avs_address_i == OFF_BUILD_CFG) |->
      (avs_readdata_o[14:12] == CFG_RD_CAP) && (avs_readdata_o[11:8] == CFG_WR_Q_DEP)
      && (avs_readdata_o[6:4] == CFG_WR_CAP) && (avs_readdata_o[2:0] == CFG_WIDTH);
  endproperty
  a_cfg_caps: assert property (p_cfg_caps) else $error("Capability fields wrong"); // [RULE3]

  property p_id0;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (rd_acc && avs_address_i == OFF_ID0) |-> avs_readdata_o == {24'h00_0000, ID_PART[7:0]};
  endproperty
  a_id0: assert property (p_id0) else $error("Id byte zero wrong"); // [RULE12]

  property p_id3;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (rd_acc && avs_address_i == OFF_ID3) |-> avs_readdata_o[0] == 1'b0;
  endproperty
  a_id3: assert property (p_id3) else $error("Integration flag set"); // [RULE13]

  property p_id2;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (rd_acc && avs_address_i == OFF_ID2) |-> avs_readdata_o[7:4] == ID_REVISION;
  endproperty
  a_id2: assert property (p_id2) else $error("Revision wrong"); // [RULE11]

  property p_wait_one;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("Read latency wrong"); // [RULE10]

  // Writes are never stalled, so a register write lands at its first edge
  property p_wr_no_wait;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (avs_write_i && !avs_read_i) |-> !avs_waitrequest_o;
  endproperty
  a_wr_no_wait: assert property (p_wr_no_wait) else $error("Write stalled"); // [RULE14]

  property p_lockup_stat;
    @(posedge ref_clk_i) disable iff (!rstn_i) lockup_i |=> irq_stat_q[IRQ_LOCKUP_BIT];
  endproperty
  a_lockup_stat: assert property (p_lockup_stat) else $error("Lockup status not set"); // [RULE7]

  property p_abort_stat;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (lockup_i && !notify_only_q) |=> irq_stat_q[IRQ_ABORT_BIT];
  endproperty
  a_abort_stat: assert property (p_abort_stat) else $error("Abort status not set"); // [RULE7]

  property p_id1;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (rd_acc && avs_address_i == OFF_ID1) |-> avs_readdata_o[3:0] == ID_PART[11:8];
  endproperty
  a_id1: assert property (p_id1) else $error("Part number high nibble wrong"); // [RULE11]

  // Upper id bits are undefined to software; this build returns zero there
  property p_id_upper;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (rd_acc && (avs_address_i == OFF_ID0 || avs_address_i == OFF_ID1
                  || avs_address_i == OFF_ID2 || avs_address_i == OFF_ID3))
      |-> avs_readdata_o[31:8] == 24'h00_0000;
  endproperty
  a_id_upper: assert property (p_id_upper) else $error("Id upper bits set"); // [RULE10]

  c_abort: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    lockup_i && !notify_only_q);
  c_notify: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    lockup_i && notify_only_q);
  c_irq: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) irq_o);
  c_id_read: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    rd_acc && avs_address_i == OFF_ID0);
  c_w1c: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    |irq_clr && |irq_stat_q);
endmodule // dcwir_regs
`default_nettype wire

// ==== verilog/dcwir_pkg.sv ====
// Package with register map, field layout and constants for the config/watchdog/id register bank
// ----------------------------------------------------------------------------
// Overview of operation
// [RULE1] Build config bits 29:20 give data buffer depth as lines minus one.
// [RULE2] Build config bits 19:16 give read queue depth as lines minus one.
// [RULE3] Build config bits 14:12 give outstanding read count minus one, 1 to 8.
// [RULE4] Build config bits 11:8 give write queue depth as lines minus one.
// [RULE5] Build config bits 6:4 give outstanding write count minus one, 1 to 8.
// [RULE6] Build config bits 2:0 code bus width: 010=32, 011=64, 100=128 bits.
// [RULE7] Mode bit clear: lock-up aborts involved channels and raises abort interrupt.
// [RULE8] Mode bit set: lock-up only raises abort interrupt, channels keep running.
// [RULE9] Software should change watchdog control only while all channels are stopped.
// [RULE10] Four id registers each give one byte in bits 7:0 of a 32-bit id.
// [RULE11] Id value: bit 24 integration, 23:20 revision, 19:12 designer, 11:0 part.
// [RULE12] Lowest id register returns part number low byte, which is also its reset value.
// [RULE13] Integration flag reads zero: no integration test logic inside.
// [RULE14] Config and id fields are read-only constants; writes ignored; reserved reads zero.
// ----------------------------------------------------------------------------
package dcwir_pkg;
  localparam int ADDR_W = 6;
  // Register byte offsets
  localparam logic [5:0] OFF_BUILD_CFG = 6'h00;
  localparam logic [5:0] OFF_WD_CTRL = 6'h04;
  localparam logic [5:0] OFF_IRQ_STAT = 6'h08;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h0C;
  localparam logic [5:0] OFF_ID0 = 6'h10;
  localparam logic [5:0] OFF_ID1 = 6'h14;
  localparam logic [5:0] OFF_ID2 = 6'h18;
  localparam logic [5:0] OFF_ID3 = 6'h1C;
  // Build configuration field values
  localparam logic [9:0] CFG_BUF_DEP = 10'h0FF;
  localparam logic [3:0] CFG_RD_Q_DEP = 4'hF;
  localparam logic [2:0] CFG_RD_CAP = 3'h7;
  localparam logic [3:0] CFG_WR_Q_DEP = 4'hF;
  localparam logic [2:0] CFG_WR_CAP = 3'h7;
  localparam logic [2:0] WIDTH_32 = 3'h2;
  localparam logic [2:0] WIDTH_64 = 3'h3;
  localparam logic [2:0] WIDTH_128 = 3'h4;
  localparam logic [2:0] CFG_WIDTH = WIDTH_64;
  // Build configuration field positions
  localparam int BUF_LSB = 20;
  localparam int RDQ_LSB = 16;
  localparam int RDC_LSB = 12;
  localparam int WRQ_LSB = 8;
  localparam int WRC_LSB = 4;
  localparam int WID_LSB = 0;
  // Identity fields; designer, part and revision values are arbitrary
  localparam logic INTEG_CFG = 1'b0;
  localparam logic [3:0] ID_REVISION = 4'h1;
  localparam logic [7:0] ID_DESIGNER = 8'h5A;
  localparam logic [11:0] ID_PART = 12'h7C4;
  localparam int ID_INTEG_BIT = 24;
  localparam int ID_REV_LSB = 20;
  localparam int ID_DES_LSB = 12;
  // Watchdog and interrupt layout
  localparam int WD_NOTIFY_BIT = 0;
  localparam logic WD_RESET = 1'b0;
  localparam int IRQ_LOCKUP_BIT = 0;
  localparam int IRQ_ABORT_BIT = 1;
  localparam int IRQ_W = 2;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

// ==== verilog/dcwir_rdata_reg.sv ====
// Registered read data stage for the register bus
`timescale 1ns/10ps
`default_nettype none
module dcwir_rdata_reg (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic load_i,
  input wire logic [31:0] data_i,
  output logic [31:0] data_o
);
  import dcwir_pkg::*;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_o <= ZERO_WORD;
    end else if (load_i) begin
      data_o <= data_i;
    end
  end
endmodule // dcwir_rdata_reg
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking testbench for the config, watchdog and identity register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(act, exp, msg) begin num_checks++; if ((act) !== (exp)) begin failures++; \
  $display("[ERR] %0t %s", $time, msg); end end
module tb;
  import dcwir_pkg::*;
  // ----------------------------------------------------------------------------
  // Signals and expected values
  // ----------------------------------------------------------------------------
  // Expected words built from field positions so a packing slip in the design shows up
  localparam logic [31:0] EXP_CFG = (32'(CFG_BUF_DEP) << BUF_LSB) | (32'(CFG_RD_Q_DEP) << RDQ_LSB)
    | (32'(CFG_RD_CAP) << RDC_LSB) | (32'(CFG_WR_Q_DEP) << WRQ_LSB)
    | (32'(CFG_WR_CAP) << WRC_LSB) | (32'(CFG_WIDTH) << WID_LSB);
  localparam logic [31:0] EXP_ID = (32'(INTEG_CFG) << ID_INTEG_BIT)
    | (32'(ID_REVISION) << ID_REV_LSB) | (32'(ID_DESIGNER) << ID_DES_LSB) | 32'(ID_PART);
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic lockup_i = 1'b0;
  logic [7:0] lockup_chans_i = 8'h00;
  logic [7:0] chan_abort_o;
  logic irq_abort_o;
  logic irq_o;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  dcwir_regs i_dcwir_regs (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .lockup_i(lockup_i), .lockup_chans_i(lockup_chans_i), .chan_abort_o(chan_abort_o),
    .irq_abort_o(irq_abort_o), .irq_o(irq_o));
  // ----------------------------------------------------------------------------
  // Bus tasks; waitrequest and read data are taken at the rising edge itself
  // ----------------------------------------------------------------------------
  task automatic bus_rd(input logic [5:0] a, output logic [31:0] d);
    int n = 0;
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    `CHK(n < 20, 1'b1, "read never answered")
    d = avs_readdata_o;
    avs_read_i <= 1'b0;
  endtask
  task automatic bus_wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
    int n = 0;
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    `CHK(n < 20, 1'b1, "write never answered")
    avs_write_i <= 1'b0;
  endtask
  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_config;
    logic [31:0] d;
    bus_rd(OFF_BUILD_CFG, d);
    `CHK(d[29:20], CFG_BUF_DEP, "buffer depth")
    `CHK(d[19:16], CFG_RD_Q_DEP, "read queue depth")
    `CHK(d[14:12], CFG_RD_CAP, "read capability")
    `CHK(d[11:8], CFG_WR_Q_DEP, "write queue depth")
    `CHK(d[6:4], CFG_WR_CAP, "write capability")
    `CHK(d[2:0] inside {WIDTH_32, WIDTH_64, WIDTH_128}, 1'b1, "width code")
    `CHK(d[2:0], CFG_WIDTH, "width value")
    // Read-only: an all-ones write must leave the word as built
    bus_wr(OFF_BUILD_CFG, 32'hFFFF_FFFF, 4'hF);
    bus_rd(OFF_BUILD_CFG, d);
    `CHK(d, EXP_CFG, "config changed by write")
    bus_rd(6'h3C, d);
    `CHK(d, ZERO_WORD, "unmapped read")
  endtask
  task automatic t_ident;
    logic [31:0] d;
    for (int i = 0; i < 4; i++) begin
      bus_wr(OFF_ID0 + 6'(4 * i), 32'hFFFF_FFFF, 4'hF);
      bus_rd(OFF_ID0 + 6'(4 * i), d);
      `CHK(d, {24'h00_0000, EXP_ID[8*i +: 8]}, "identity byte")
      if (i == 0) `CHK(d[7:0], ID_PART[7:0], "part low byte")
      if (i == 1) `CHK({d[3:0], 4'h0}, {ID_PART[11:8], 4'h0}, "part high nibble")
      if (i == 2) `CHK(d[7:4], ID_REVISION, "revision")
      if (i == 3) `CHK(d[0], 1'b0, "integration flag")
    end
  endtask
  task automatic t_mode_reg;
    logic [31:0] d;
    bus_rd(OFF_WD_CTRL, d);
    `CHK(d, {31'h0, WD_RESET}, "mode reset value")
    // Byte lane zero disabled: write must be dropped
    bus_wr(OFF_WD_CTRL, 32'hFFFF_FFFF, 4'hE);
    bus_rd(OFF_WD_CTRL, d);
    `CHK(d, {31'h0, WD_RESET}, "masked write took effect")
    bus_wr(OFF_WD_CTRL, 32'hFFFF_FFFF, 4'hF);
    bus_rd(OFF_WD_CTRL, d);
    `CHK(d, 32'h0000_0001, "mode bit or reserved bits")
  endtask
  task automatic t_lockup(input logic mode);
    logic [31:0] d;
    // Mode only changes while no lock-up is pending, channels idle
    bus_wr(OFF_WD_CTRL, {31'h0, mode}, 4'hF);
    @(posedge ref_clk_i);
    lockup_i <= 1'b1;
    lockup_chans_i <= 8'hA5;
    @(posedge ref_clk_i);
    lockup_i <= 1'b0;
    lockup_chans_i <= 8'h00;
    @(negedge ref_clk_i);
    `CHK(chan_abort_o, mode ? 8'h00 : 8'hA5, "channel abort")
    `CHK(irq_abort_o, 1'b1, "abort interrupt")
    @(negedge ref_clk_i);
    `CHK({irq_abort_o, chan_abort_o}, 9'h000, "abort outputs linger")
    bus_rd(OFF_IRQ_STAT, d);
    `CHK(d[IRQ_LOCKUP_BIT], 1'b1, "lockup status")
    `CHK(d[IRQ_ABORT_BIT], ~mode, "channels aborted status")
    `CHK(irq_o, 1'b0, "masked interrupt")
    bus_wr(OFF_IRQ_MASK, 32'h0000_0003, 4'hF);
    @(negedge ref_clk_i);
    `CHK(irq_o, 1'b1, "unmasked interrupt")
    bus_wr(OFF_IRQ_STAT, 32'h0000_0003, 4'hF);
    @(negedge ref_clk_i);
    `CHK(irq_o, 1'b0, "interrupt after clear")
    bus_rd(OFF_IRQ_STAT, d);
    `CHK(d, ZERO_WORD, "status after clear")
    bus_wr(OFF_IRQ_MASK, ZERO_WORD, 4'hF);
  endtask
  // ----------------------------------------------------------------------------
  // Verdict, hang guard and main sequence
  // ----------------------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      $display("[ERR] %0t run timed out", $time);
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    t_config();
    t_ident();
    t_mode_reg();
    t_lockup(1'b0);
    t_lockup(1'b1);
    finish_test();
  end
endmodule // tb
`default_nettype wire
